/* include/nvb_pkg.sv */
// Purpose: shared constants for the nonvolatile byte access controller
// Assumes: 8-bit special function register space, one clock
// Notes:   indices select registers on the core's data bus
package nvb_pkg;
	localparam int          NVB_DEPTH        = 128;
	localparam int          NVB_AW           = 7;
	localparam logic [7:0]  NVB_CTRL_OFF     = 8'h40;
	localparam logic [7:0]  NVB_CTRL_SECTION = 8'h01;
	localparam logic [7:0]  NVB_INDEX_OFF    = 8'h5A;
	localparam logic [7:0]  NVB_VALUE_OFF    = 8'h5B;
	localparam logic [7:0]  NVB_FLAG_OFF     = 8'h5C;
	localparam int          NVB_BIT_FETCH    = 0;
	localparam int          NVB_BIT_FETCH_EN = 1;
	localparam int          NVB_BIT_PROG     = 2;
	localparam int          NVB_BIT_PROG_EN  = 3;
	localparam int          NVB_BIT_DONE     = 0;
	localparam int          NVB_BIT_DONE_IE  = 1;
	localparam logic [7:0]  NVB_CTRL_RST     = 8'h00;
	localparam logic [7:0]  NVB_FLAG_RST     = 8'h00;
	localparam int          NVB_FETCH_CYC    = 2;
	localparam int          NVB_PROG_TICKS   = 40;
	localparam int          NVB_TIMER_DIV    = 7;
	typedef enum logic [1:0] {
		NVB_IDLE  = 2'b00,
		NVB_FETCH = 2'b01,
		NVB_PROG  = 2'b10
	} nvb_state_t;
endpackage : nvb_pkg

/* design/nvb_prog_timer.sv */
// Purpose: free running program cycle timer, unrelated in phase to the core
// Assumes: ring oscillator modelled as enable pulses from a divider
// Notes:   o_done pulses once after the programmed number of ticks
`timescale 1ns/1ps
`default_nettype none
module nvb_prog_timer
	import nvb_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_nrst,
	input  wire logic i_start,
	output logic      o_done
);
	logic [3:0] div;
	logic [7:0] ticks;
	logic       run;
	wire        tick = (div == 4'(NVB_TIMER_DIV));

	// divider runs free, so completion is not a fixed count from start
	always_ff @(posedge i_mclk) begin
		if (!i_nrst || tick) div <= 4'h0;
		else div <= div + 4'h1;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			run    <= 1'b0;
			ticks  <= 8'h00;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !run) begin
				run   <= 1'b1;
				ticks <= 8'h00;
			end else if (run && tick) begin
				if (ticks == 8'(NVB_PROG_TICKS - 1)) begin
					run    <= 1'b0;
					o_done <= 1'b1;
				end else ticks <= ticks + 8'h01;
			end
		end
	end
endmodule : nvb_prog_timer
`default_nettype wire

/* design/nvb_array.sv */
// Purpose: 128 by 8 nonvolatile byte array model
// Assumes: one byte per access, registered read
// Notes:   contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module nvb_array
	import nvb_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic [NVB_AW-1:0] i_addr,
	input  wire logic              i_wr,
	input  wire logic [7:0]        i_wdata,
	output logic      [7:0]        o_rdata
);
	logic [7:0] mem [NVB_DEPTH];

	always_ff @(posedge i_mclk) begin
		if (i_wr) mem[i_addr] <= i_wdata;
		o_rdata <= mem[i_addr];
	end
endmodule : nvb_array

/* design/nvb_ctrl.sv */
// Contract
// - 128 byte array, only via access registers
// - single byte transfers through three registers
// - index register seven bits, bit seven zero
// - value register carries eight data bits
// - fetch start ignored without fetch enable
// - read end clears fetch start, byte kept
// - value held until next read or write
// - program start ignored without program enable
// - write timed by free running timer
// - write end clears program start bit
// - interrupt available for write end
// - reset clears program enable
// - write end sets done and shared flags
//
// Purpose: byte access controller for the on-chip nonvolatile array
// Assumes: core bus strobes are one cycle, synchronous to i_mclk
// Notes:   control register decoded only through indirect_port1 with pointer1
`timescale 1ns/1ps
`default_nettype none
module nvb_ctrl
	import nvb_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	input  wire logic [7:0] i_addr,
	input  wire logic       i_indirect,
	input  wire logic [7:0] i_pointer1_low,
	input  wire logic [7:0] i_pointer1_high,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_mf_clear,
	output logic      [7:0] o_rdata,
	output logic            o_mf_flag,
	output logic            o_irq
);
	logic [7:0]   nv_byte_index;
	logic [7:0]   nv_byte_value;
	logic [3:0]   nv_access_control;
	logic         nv_done_flag;
	logic         nv_done_irq_enable;
	logic [1:0]   fcnt;
	logic [7:0]   arr_rdata;
	logic         prog_done;
	nvb_state_t   state;
	nvb_state_t   next_state;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// control reachable only through the indirect port with pointer1 set
	wire ctrl_sel  = i_indirect && hit(i_pointer1_low, NVB_CTRL_OFF)
		&& hit(i_pointer1_high, NVB_CTRL_SECTION);
	wire index_sel = !i_indirect && hit(i_addr, NVB_INDEX_OFF);
	wire value_sel = !i_indirect && hit(i_addr, NVB_VALUE_OFF);
	wire flag_sel  = !i_indirect && hit(i_addr, NVB_FLAG_OFF);
	wire ctrl_wr   = i_wr && ctrl_sel;
	wire fetch_req = ctrl_wr && i_wdata[NVB_BIT_FETCH] && i_wdata[NVB_BIT_FETCH_EN];
	wire prog_req  = ctrl_wr && i_wdata[NVB_BIT_PROG]
		&& (i_wdata[NVB_BIT_PROG_EN] || nv_access_control[NVB_BIT_PROG_EN]);
	wire start_fetch = (state == NVB_IDLE) && fetch_req && !prog_req;
	wire start_prog  = (state == NVB_IDLE) && prog_req;
	wire fetch_end   = (state == NVB_FETCH) && (fcnt == 2'(NVB_FETCH_CYC - 1));
	wire prog_end    = (state == NVB_PROG) && prog_done;
	wire busy        = (state != NVB_IDLE);

	always_comb begin
		next_state = state;
		case (state)
			NVB_IDLE: begin
				if (start_prog) next_state = NVB_PROG;
				else if (start_fetch) next_state = NVB_FETCH;
			end
			NVB_FETCH: begin
				if (fetch_end) next_state = NVB_IDLE;
			end
			NVB_PROG: begin
				if (prog_end) next_state = NVB_IDLE;
			end
			default: next_state = NVB_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) state <= NVB_IDLE;
		else state <= next_state;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst || state != NVB_FETCH) fcnt <= 2'b00;
		else fcnt <= fcnt + 2'b01;
	end

	nvb_array u_array (
		.i_mclk  (i_mclk),
		.i_addr  (nv_byte_index[NVB_AW-1:0]),
		.i_wr    (start_prog),
		.i_wdata (nv_byte_value),
		.o_rdata (arr_rdata)
	);

	nvb_prog_timer u_timer (
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_start (start_prog),
		.o_done  (prog_done)
	);

	// bus writes to index and value are ignored while a cycle is in flight; fetch end still loads value
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			nv_byte_index <= 8'h00;
		end else if (i_wr && index_sel && !busy) begin
			nv_byte_index <= {1'b0, i_wdata[6:0]};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			nv_byte_value <= 8'h00;
		end else if (fetch_end) begin
			nv_byte_value <= arr_rdata;
		end else if (i_wr && value_sel && !busy) begin
			nv_byte_value <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			nv_access_control <= NVB_CTRL_RST[3:0];
		end else begin
			if (ctrl_wr) begin
				nv_access_control[NVB_BIT_FETCH_EN] <= i_wdata[NVB_BIT_FETCH_EN];
				nv_access_control[NVB_BIT_PROG_EN]  <= i_wdata[NVB_BIT_PROG_EN];
			end
			if (start_fetch) nv_access_control[NVB_BIT_FETCH] <= 1'b1;
			else if (fetch_end) nv_access_control[NVB_BIT_FETCH] <= 1'b0;
			if (start_prog) nv_access_control[NVB_BIT_PROG] <= 1'b1;
			else if (prog_end) nv_access_control[NVB_BIT_PROG] <= 1'b0;
		end
	end

	// done flag: hardware set wins over software clear
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			nv_done_flag       <= NVB_FLAG_RST[NVB_BIT_DONE];
			nv_done_irq_enable <= NVB_FLAG_RST[NVB_BIT_DONE_IE];
			o_mf_flag          <= 1'b0;
		end else begin
			if (i_wr && flag_sel) begin
				nv_done_flag       <= i_wdata[NVB_BIT_DONE];
				nv_done_irq_enable <= i_wdata[NVB_BIT_DONE_IE];
			end
			if (prog_end) nv_done_flag <= 1'b1;
			if (prog_end) o_mf_flag <= 1'b1;
			else if (i_mf_clear) o_mf_flag <= 1'b0;
		end
	end

	assign o_irq = nv_done_flag && nv_done_irq_enable && o_mf_flag;

	wire [7:0] rd_mux = ctrl_sel  ? {4'h0, nv_access_control}
		: index_sel ? nv_byte_index
		: value_sel ? nv_byte_value
		: flag_sel  ? {6'h00, nv_done_irq_enable, nv_done_flag}
		: 8'h00;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) o_rdata <= 8'h00;
		else if (i_rd) o_rdata <= rd_mux;
	end
endmodule : nvb_ctrl
`default_nettype wire

/* testbench/nvb_ctrl_checker.sv */
// Purpose: port level checks for the byte access controller
// Assumes: one clock, synchronous active low reset
// Notes:   bound into nvb_ctrl
`timescale 1ns/1ps
`default_nettype none
module nvb_ctrl_checker
	import nvb_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic       i_indirect,
	input wire logic [7:0] i_pointer1_low,
	input wire logic [7:0] i_pointer1_high,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] i_wdata,
	input wire logic       i_mf_clear,
	input wire logic [7:0] o_rdata,
	input wire logic       o_mf_flag,
	input wire logic       o_irq
);
	wire logic ctl = i_indirect && i_pointer1_low == NVB_CTRL_OFF
		&& i_pointer1_high == NVB_CTRL_SECTION;
	wire logic s_i = !i_indirect && i_addr == NVB_INDEX_OFF;
	wire logic s_f = !i_indirect && i_addr == NVB_FLAG_OFF;
	wire logic s_n = !i_indirect && !(i_addr inside {NVB_INDEX_OFF, NVB_VALUE_OFF, NVB_FLAG_OFF});
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	property p_irq; o_irq |-> o_mf_flag; endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_mf; o_mf_flag && !i_mf_clear |=> o_mf_flag; endproperty
	a_mf: assert property (p_mf) else $error("flag dropped");
	property p_hold; !i_rd |=> $stable(o_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unm; i_rd && s_n |=> o_rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped not zero");
	property p_idx; i_rd && s_i |=> !o_rdata[7]; endproperty
	a_idx: assert property (p_idx) else $error("index bit7 set");
	property p_ctl; i_rd && ctl |=> o_rdata[7:4] == 4'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("control high bits");
	property p_ib; i_wr && s_i ##1 !i_wr ##1 i_rd && s_i |=> o_rdata == ($past(i_wdata, 3) & 8'h7F);
	endproperty
	a_ib: assert property (p_ib) else $error("index readback");
	property p_ie; i_wr && s_f ##1 !i_wr ##1 i_rd && s_f |=> o_rdata[1] == $past(i_wdata[1], 3);
	endproperty
	a_ie: assert property (p_ie) else $error("enable readback");
	property p_fen; i_wr && ctl && i_wdata[3:0] == 4'h1 ##1 !i_wr ##1 i_rd && ctl |=> !o_rdata[0];
	endproperty
	a_fen: assert property (p_fen) else $error("fetch ran without enable");
endmodule : nvb_ctrl_checker
bind nvb_ctrl nvb_ctrl_checker chk (
	.i_mclk          (i_mclk),
	.i_nrst          (i_nrst),
	.i_addr          (i_addr),
	.i_indirect      (i_indirect),
	.i_pointer1_low  (i_pointer1_low),
	.i_pointer1_high (i_pointer1_high),
	.i_wr            (i_wr),
	.i_rd            (i_rd),
	.i_wdata         (i_wdata),
	.i_mf_clear      (i_mf_clear),
	.o_rdata         (o_rdata),
	.o_mf_flag       (o_mf_flag),
	.o_irq           (o_irq)
);
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: directed bench for the byte access controller
// Assumes: one-cycle strobes driven on the falling edge
// Notes:   start bits are polled under a bound
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value %0t: %h not %h", $time, (a), (b)); end end
`define WR(a, v) acc(1'b1, 1'b0, a, v)
`define RD(a) acc(1'b0, 1'b0, a, 8'h00)
`define WC(v) acc(1'b1, 1'b1, 8'h00, v)
`define RC acc(1'b0, 1'b1, 8'h00, 8'h00)
module testbench;
	import nvb_pkg::*;
	logic       i_mclk = 1'b0, i_nrst = 1'b0, i_indirect = 1'b0;
	logic       i_wr = 1'b0, i_rd = 1'b0, i_mf_clear = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, d = 8'h00, o_rdata;
	logic [7:0] i_pointer1_low = NVB_CTRL_OFF, i_pointer1_high = NVB_CTRL_SECTION;
	logic       o_mf_flag, o_irq;
	logic [7:0] ix [2] = '{8'h00, 8'h7F};
	logic [7:0] vx [2] = '{8'hA5, 8'h5A};
	int         n_fail = 0, n_checks = 0;
	always #20 i_mclk = ~i_mclk;
	nvb_ctrl dut (
		.i_mclk          (i_mclk),
		.i_nrst          (i_nrst),
		.i_addr          (i_addr),
		.i_indirect      (i_indirect),
		.i_pointer1_low  (i_pointer1_low),
		.i_pointer1_high (i_pointer1_high),
		.i_wr            (i_wr),
		.i_rd            (i_rd),
		.i_wdata         (i_wdata),
		.i_mf_clear      (i_mf_clear),
		.o_rdata         (o_rdata),
		.o_mf_flag       (o_mf_flag),
		.o_irq           (o_irq)
	);
	task automatic acc(input logic w, input logic c, input logic [7:0] a, input logic [7:0] v);
		@(negedge i_mclk);
		i_wr = w;
		i_rd = !w;
		i_indirect = c;
		i_addr = a;
		i_wdata = v;
		@(negedge i_mclk);
		i_wr = 1'b0;
		i_rd = 1'b0;
		d = o_rdata;
	endtask : acc
	task automatic poll(input int b);
		int k;
		for (k = 0; k < 500; k++) begin
			`RC;
			if (d[b] === 1'b0) break;
		end
		`CHK(k < 500, 1'b1)
	endtask : poll
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	initial begin
		#200000;
		n_fail++;
		results();
	end
	initial begin
		repeat (4) @(negedge i_mclk);
		i_nrst = 1'b1;
		`RC;
		`CHK(d, NVB_CTRL_RST)
		`RD(NVB_FLAG_OFF);
		`CHK(d, NVB_FLAG_RST)
		`WR(NVB_INDEX_OFF, 8'hFF);
		`RD(NVB_INDEX_OFF);
		`CHK(d, 8'h7F)
		`RD(8'h10);
		`CHK(d, 8'h00)
		`WC(8'h01);
		`RC;
		`CHK(d, 8'h00)
		`WC(8'h04);
		`RC;
		`CHK(d, 8'h00)
		i_pointer1_high = 8'h00;
		`WC(8'h0B);
		i_pointer1_high = NVB_CTRL_SECTION;
		`WR(NVB_CTRL_OFF, 8'h0B);
		`RC;
		`CHK(d, 8'h00)
		`WR(NVB_FLAG_OFF, 8'h02);
		foreach (ix[i]) begin
			`WR(NVB_INDEX_OFF, ix[i]);
			`WR(NVB_VALUE_OFF, vx[i]);
			`WC(8'h08);
			`WC(8'h0C);
			`RC;
			`CHK(d, 8'h0C)
			`CHK(o_mf_flag, 1'b0)
			poll(NVB_BIT_PROG);
			`CHK(o_mf_flag, 1'b1)
			`CHK(o_irq, 1'b1)
			@(negedge i_mclk);
			i_mf_clear = 1'b1;
			@(negedge i_mclk);
			i_mf_clear = 1'b0;
			`CHK(o_irq, 1'b0)
			`RD(NVB_FLAG_OFF);
			`CHK(d, 8'h03)
			`WR(NVB_FLAG_OFF, 8'h02);
			`RD(NVB_FLAG_OFF);
			`CHK(d, 8'h02)
			`WC(8'h00);
		end
		foreach (ix[i]) begin
			`WR(NVB_VALUE_OFF, 8'h00);
			`WC(8'h02);
			`WR(NVB_INDEX_OFF, ix[i]);
			`WC(8'h03);
			poll(NVB_BIT_FETCH);
			`RD(NVB_VALUE_OFF);
			`CHK(d, vx[i])
			`RD(NVB_INDEX_OFF);
			`RD(NVB_VALUE_OFF);
			`CHK(d, vx[i])
		end
		`WC(8'h08);
		`RC;
		`CHK(d, 8'h08)
		i_nrst = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_nrst = 1'b1;
		`RC;
		`CHK(d, NVB_CTRL_RST)
		results();
	end
endmodule : testbench
`default_nettype wire
